// ### rtl/ftcan_pkg.sv
// Shared constants of the fault tolerant CAN mode controller
// Behaviour
// - Two pins pick standby, go-sleep, listen, normal
// - Low power modes neither send nor receive
// - Sleep floats inhibit, low termination to battery
// - Logic supply loss after go-sleep means sleep
// - Wake goes to standby, inhibit drives regulator
// - Both edges of local wake input count
// - Wakes accepted only after filter time
// - With logic supply, wake pulls flags low
// - Standby like sleep but inhibit stays active
// - Power-on starts in battery standby
// - Receive-only passes data, drivers stay off
// - Receive-only: wake on data, flag shows power-on
// - Entering normal clears power-on and wake flags
// - Supply loss forces standby, sleep or power-down
// - Normal: error flag on failure, data out
// - Delayed single-wire entry and delayed recovery
// - Dominant-only failures held until next word
// - Line failures cut that line's termination, driver
// - Bus wake from either line alone
// - Over-temperature disables drivers only
// - Low transmit input drives bus dominant
package ftcan_pkg;
	// Operating modes
	typedef enum logic [2:0] {
		ST_STANDBY   = 3'b000,
		ST_SLEEP     = 3'b001,
		ST_GOSLEEP   = 3'b010,
		ST_RXONLY    = 3'b011,
		ST_NORMAL    = 3'b100,
		ST_POWERDOWN = 3'b101
	} mode_type;
	// Clock rate and times in microseconds
	localparam int CLK_MHZ      = 250;
	localparam int GTS_HOLD_US  = 50;
	localparam int WAKE_FILT_US = 10;
	localparam int FAIL_ON_US   = 20;
	localparam int FAIL_OFF_US  = 40;
	localparam int IDLE_US      = 88;
	// Derived cycle counts
	localparam int GTS_HOLD_CYC  = GTS_HOLD_US * CLK_MHZ;
	localparam int WAKE_FILT_CYC = WAKE_FILT_US * CLK_MHZ;
	localparam int FAIL_ON_CYC   = FAIL_ON_US * CLK_MHZ;
	localparam int FAIL_OFF_CYC  = FAIL_OFF_US * CLK_MHZ;
	localparam int IDLE_CYC      = IDLE_US * CLK_MHZ;
	localparam int CNT_W         = 16;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	// Control fields and reset value
	localparam int         CTRL_LWAKE_BIT = 0;
	localparam int         CTRL_BWAKE_BIT = 1;
	localparam logic [1:0] CTRL_RST       = 2'h3;
	// Status fields
	localparam int ST_MODE_LSB  = 0;
	localparam int ST_PON_BIT   = 3;
	localparam int ST_WAKE_BIT  = 4;
	localparam int ST_SFAIL_BIT = 5;
	localparam int ST_DISH_BIT  = 6;
	localparam int ST_DISL_BIT  = 7;
	localparam int ST_OT_BIT    = 8;
	localparam int ST_GTS_BIT   = 9;
endpackage : ftcan_pkg

// ### rtl/sig_pair_if.sv
// Raw and delayed level pair between the top and its filters
`timescale 1ns/1ns
`default_nettype none
interface sig_pair_if;
	logic raw; // Level before filtering
	logic fil; // Level after filtering
	modport unit (input raw, output fil);
	modport user (output raw, input fil);
endinterface : sig_pair_if
`default_nettype wire

// ### rtl/stable_filter.sv
// Symmetric stability filter: output follows a level held long enough
`timescale 1ns/1ns
`default_nettype none
module stable_filter #(
	parameter int                CNT_W = 16,
	parameter logic [CNT_W-1:0]  HOLD  = 16'd1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Level pair
	sig_pair_if.unit sp
);
	logic [CNT_W-1:0] cnt_r; // Cycles the input has differed
	logic             fil_r; // Accepted level
	wire              same = (sp.raw == fil_r);
	wire              done = (cnt_r >= HOLD - 1'b1);
	// Short excursions restart the count, so transients never pass
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= '0;
			fil_r <= 1'b0;
		end else if (same) begin
			cnt_r <= '0;
		end else if (done) begin
			fil_r <= sp.raw;
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
	assign sp.fil = fil_r;
endmodule : stable_filter
`default_nettype wire

// ### rtl/fail_delay.sv
// Asymmetric delay: separate entry and recovery times for a failure
`timescale 1ns/1ns
`default_nettype none
module fail_delay #(
	parameter int                CNT_W  = 16,
	parameter logic [CNT_W-1:0]  ON_CY  = 16'd1,
	parameter logic [CNT_W-1:0]  OFF_CY = 16'd1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Level pair
	sig_pair_if.unit sp
);
	logic [CNT_W-1:0] cnt_r; // Cycles of disagreement
	logic             fil_r; // Failure taken as present
	wire [CNT_W-1:0]  lim  = fil_r ? OFF_CY : ON_CY;
	wire              same = (sp.raw == fil_r);
	wire              done = (cnt_r >= lim - 1'b1);
	// Entry and recovery each need their own settled time
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= '0;
			fil_r <= 1'b0;
		end else if (same) begin
			cnt_r <= '0;
		end else if (done) begin
			fil_r <= sp.raw;
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
	assign sp.fil = fil_r;
endmodule : fail_delay
`default_nettype wire

// ### rtl/ftcan_mode_ctrl.sv
// Mode, wake-up and bus failure control of a fault tolerant CAN transceiver
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ftcan_mode_ctrl #(
	parameter int unsigned GTS_CYC  = ftcan_pkg::GTS_HOLD_CYC,
	parameter int unsigned WAKE_CYC = ftcan_pkg::WAKE_FILT_CYC,
	parameter int unsigned FON_CYC  = ftcan_pkg::FAIL_ON_CYC,
	parameter int unsigned FOFF_CYC = ftcan_pkg::FAIL_OFF_CYC,
	parameter int unsigned IDLE_CY  = ftcan_pkg::IDLE_CYC
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Host side pins
	input  wire logic        standby_not_input_in,
	input  wire logic        transfer_enable_input_in,
	input  wire logic        transmit_line_in,
	input  wire logic        local_edge_trigger_input_in,
	output logic             receive_line_out,
	output logic             error_flag_n_out,
	output logic             regulator_inhibit_output_out,
	output logic             regulator_inhibit_oe_n_out,
	output logic             pullup_en_out,
	// Bus receivers and detectors
	input  wire logic        diff_dominant_in,
	input  wire logic        canh_dominant_in,
	input  wire logic        canl_dominant_in,
	input  wire logic        short_fail_in,
	input  wire logic        canh_fail_in,
	input  wire logic        canl_fail_in,
	// Supplies and temperature
	input  wire logic        battery_ok_in,
	input  wire logic        logic_ok_in,
	input  wire logic        overtemp_in,
	// Bus drivers and terminations
	output logic             canh_drive_en_out,
	output logic             canl_drive_en_out,
	output logic             bus_dominant_out,
	output logic             high_line_termination_en_out,
	output logic             low_line_termination_en_out,
	output logic             low_line_termination_bat_out
);
	import ftcan_pkg::*;
	// Counts cut to counter width
	localparam logic [CNT_W-1:0] GTS_W  = CNT_W'(GTS_CYC);
	localparam logic [CNT_W-1:0] WAKE_W = CNT_W'(WAKE_CYC);
	localparam logic [CNT_W-1:0] FON_W  = CNT_W'(FON_CYC);
	localparam logic [CNT_W-1:0] FOFF_W = CNT_W'(FOFF_CYC);
	localparam logic [CNT_W-1:0] IDLE_W = CNT_W'(IDLE_CY);
	// Bus slave state
	logic        dph_ctrl_r;  // Data phase writes control
	logic [31:0] hrdata_r;    // Read data, set in address phase
	logic [1:0]  ctrl_r;      // Wake source enables
	logic [31:0] status_w;    // Live status word
	logic [31:0] rd_word;     // Selected read word
	// Mode and flags
	mode_type         mode_r;      // Current mode
	mode_type         mode_nxt;    // Next mode
	logic [CNT_W-1:0] gts_cnt_r;   // Time spent in go-to-sleep
	logic             pon_r;       // Battery power-on flag
	logic             wake_pend_r; // Wake request not yet released
	logic             sfail_r;     // Dominant-only failure held
	logic [CNT_W-1:0] idle_cnt_r;  // Recessive run length
	logic             lw_prev_r;   // Last filtered local level
	logic             bw_prev_r;   // Last filtered bus wake level
	// Registered pin drives
	logic rxd_r, rxd_nxt;
	logic error_flag_n_r, error_flag_n_nxt;
	logic inh_oe_n_r, pullup_r;
	logic canh_en_r, canl_en_r;
	logic bus_dom_r, hterm_r;
	logic lterm_r, lbat_r;
	// Filter inputs and outputs
	logic [1:0] raw_w;  // Raw levels: local, bus
	logic [1:0] wfil_w; // Filtered wake levels
	logic [1:0] fraw_w; // Raw line failures: high, low
	logic [1:0] ffil_w; // Delayed line failures
	// Address phase decode
	wire addr_ok  = hsel_in && htrans_in[1] && hready_in;
	wire hi_zero  = (haddr_in[31:8] == 24'h000000);
	wire hit_ctrl = hi_zero && (haddr_in[7:0] == ADDR_CTRL);
	wire hit_stat = hi_zero && (haddr_in[7:0] == ADDR_STATUS);
	wire wr_ctrl  = addr_ok && hwrite_in && hit_ctrl;
	wire rd_take  = addr_ok && !hwrite_in;
	// Control value a read sees, with a write in flight forwarded
	wire [1:0] ctrl_view = dph_ctrl_r ? hwdata_in[1:0] : ctrl_r;
	// Mode groups
	wire in_sleep  = (mode_r == ST_SLEEP);
	wire in_stby   = (mode_r == ST_STANDBY);
	wire in_gts    = (mode_r == ST_GOSLEEP);
	wire in_normal = (mode_r == ST_NORMAL);
	wire low_power = in_sleep || in_stby || in_gts;
	wire gts_done  = (gts_cnt_r == GTS_W);
	wire enter_nrm = (mode_nxt == ST_NORMAL) && !in_normal;
	// Line failures and wake events after filtering
	wire dis_h      = ffil_w[0];
	wire dis_l      = ffil_w[1];
	wire local_edge = (wfil_w[0] != lw_prev_r);
	wire bus_rise   = wfil_w[1] && !bw_prev_r;
	wire wake_evt   = (local_edge && ctrl_r[CTRL_LWAKE_BIT])
	                || (bus_rise && ctrl_r[CTRL_BWAKE_BIT]);
	// Received bus level, single-wire when only one line is cut
	wire bus_dom_rx = (dis_l && !dis_h) ? canh_dominant_in :
	                  (dis_h && !dis_l) ? canl_dominant_in :
	                  diff_dominant_in;
	wire word_start = bus_dom_rx && (idle_cnt_r == IDLE_W);
	wire fail_any   = sfail_r || dis_h || dis_l;
	wire tx_ok      = in_normal && !overtemp_in;
	wire wake_show  = wake_pend_r && logic_ok_in;
	// Filter inputs
	assign raw_w[0]  = local_edge_trigger_input_in;
	assign raw_w[1]  = canh_dominant_in || canl_dominant_in;
	assign fraw_w[0] = canh_fail_in;
	assign fraw_w[1] = canl_fail_in;
	// One wake filter and one failure delay per channel
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			sig_pair_if wk_if ();
			sig_pair_if fl_if ();
			assign wk_if.raw  = raw_w[gi];
			assign wfil_w[gi] = wk_if.fil;
			assign fl_if.raw  = fraw_w[gi];
			assign ffil_w[gi] = fl_if.fil;
			stable_filter #(
				.CNT_W (CNT_W),
				.HOLD  (WAKE_W)
			) u_wake (
				.clk_in (clk_in),
				.rst_in (rst_in),
				.sp     (wk_if)
			);
			fail_delay #(
				.CNT_W  (CNT_W),
				.ON_CY  (FON_W),
				.OFF_CY (FOFF_W)
			) u_fail (
				.clk_in (clk_in),
				.rst_in (rst_in),
				.sp     (fl_if)
			);
		end
	endgenerate
	// Status word assembly
	always_comb begin
		status_w = 32'h00000000;
		status_w[ST_MODE_LSB +: 3] = mode_r;
		status_w[ST_PON_BIT]       = pon_r;
		status_w[ST_WAKE_BIT]      = wake_pend_r;
		status_w[ST_SFAIL_BIT]     = sfail_r;
		status_w[ST_DISH_BIT]      = dis_h;
		status_w[ST_DISL_BIT]      = dis_l;
		status_w[ST_OT_BIT]        = overtemp_in;
		status_w[ST_GTS_BIT]       = gts_done;
	end
	// Read selection; unmapped addresses read zero
	assign rd_word = hit_ctrl ? {30'h00000000, ctrl_view} :
	                 hit_stat ? status_w : 32'h00000000;
	// Zero wait state slave, always OKAY
	assign hrdata_out    = hrdata_r;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	// Address phase capture and read data
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dph_ctrl_r <= 1'b0;
			hrdata_r   <= 32'h00000000;
		end else begin
			dph_ctrl_r <= wr_ctrl;
			if (rd_take) begin
				hrdata_r <= rd_word;
			end
		end
	end

	// Control register write in data phase
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_r <= CTRL_RST;
		end else if (dph_ctrl_r) begin
			ctrl_r <= hwdata_in[1:0];
		end
	end

	// Next mode; battery loss outranks wake, wake outranks logic supply loss and pins
	always_comb begin
		mode_nxt = mode_r;
		if (!battery_ok_in) begin
			mode_nxt = ST_STANDBY;
		end else if (wake_evt && in_sleep) begin
			mode_nxt = ST_STANDBY;
		end else if (!logic_ok_in) begin
			// Host unpowered: pins mean nothing now
			if (in_gts || in_sleep) begin
				mode_nxt = ST_SLEEP;
			end else if (!in_stby) begin
				mode_nxt = ST_POWERDOWN;
			end
		end else begin
			unique case ({standby_not_input_in, transfer_enable_input_in})
				2'b11: mode_nxt = ST_NORMAL;
				2'b10: mode_nxt = ST_RXONLY;
				2'b01: mode_nxt = ST_GOSLEEP;
				2'b00: begin
					// Sleep only after a full go-to-sleep hold
					if (in_gts) begin
						mode_nxt = gts_done ? ST_SLEEP : ST_STANDBY;
					end else if (!in_sleep) begin
						mode_nxt = ST_STANDBY;
					end
				end
			endcase
		end
	end

	// Mode register; power-on lands in standby
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_r <= ST_STANDBY;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// Go-to-sleep hold timer, saturating
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gts_cnt_r <= '0;
		end else if (!in_gts) begin
			gts_cnt_r <= '0;
		end else if (!gts_done) begin
			gts_cnt_r <= gts_cnt_r + 1'b1;
		end
	end

	// Power-on and wake flags; a new set wins over the clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pon_r       <= 1'b1;
			wake_pend_r <= 1'b0;
		end else begin
			pon_r       <= !battery_ok_in || (pon_r && !enter_nrm);
			wake_pend_r <= (wake_evt && !in_normal)
			             || (wake_pend_r && !enter_nrm);
		end
	end

	// Wake edge history
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lw_prev_r <= 1'b0;
			bw_prev_r <= 1'b0;
		end else begin
			lw_prev_r <= wfil_w[0];
			bw_prev_r <= wfil_w[1];
		end
	end

	// Recessive run length, marks where the next word begins
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_cnt_r <= '0;
		end else if (bus_dom_rx) begin
			idle_cnt_r <= '0;
		end else if (idle_cnt_r != IDLE_W) begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end

	// Dominant-only failures: seen while dominant, kept till next word
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sfail_r <= 1'b0;
		end else begin
			sfail_r <= (short_fail_in && bus_dom_rx)
			         || (sfail_r && !word_start);
		end
	end

	// Error flag per mode
	always_comb begin
		unique case (mode_r)
			ST_NORMAL:    error_flag_n_nxt = !fail_any;
			ST_RXONLY:    error_flag_n_nxt = !pon_r;
			ST_POWERDOWN: error_flag_n_nxt = 1'b1;
			ST_STANDBY,
			ST_SLEEP,
			ST_GOSLEEP:   error_flag_n_nxt = !wake_show;
			default:      error_flag_n_nxt = 1'b1;                     // Illegal code
		endcase
	end

	// Receive line per mode; low power never passes bus data
	always_comb begin
		unique case (mode_r)
			ST_NORMAL:    rxd_nxt = !bus_dom_rx;
			ST_RXONLY:    rxd_nxt = !(bus_dom_rx || wake_pend_r);
			ST_POWERDOWN: rxd_nxt = 1'b1;
			ST_STANDBY,
			ST_SLEEP,
			ST_GOSLEEP:   rxd_nxt = !wake_show;
			default:      rxd_nxt = 1'b1;                      // Illegal code
		endcase
	end

	// Host-side pin registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rxd_r      <= 1'b1;
			error_flag_n_r     <= 1'b1;
			inh_oe_n_r <= 1'b0;
			pullup_r   <= 1'b0;
		end else begin
			rxd_r      <= rxd_nxt;
			error_flag_n_r     <= error_flag_n_nxt;
			inh_oe_n_r <= in_sleep || (in_gts && gts_done);
			pullup_r   <= !(in_sleep || in_stby);
		end
	end

	// Bus-side driver and termination registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			canh_en_r <= 1'b0;
			canl_en_r <= 1'b0;
			bus_dom_r <= 1'b0;
			hterm_r   <= 1'b1;
			lterm_r   <= 1'b1;
			lbat_r    <= 1'b1;
		end else begin
			canh_en_r <= tx_ok && !dis_h;
			canl_en_r <= tx_ok && !dis_l;
			bus_dom_r <= tx_ok && !transmit_line_in;
			hterm_r   <= !dis_h;
			lterm_r   <= !dis_l;
			lbat_r    <= low_power;
		end
	end

	// Output drives
	assign receive_line_out             = rxd_r;
	assign error_flag_n_out             = error_flag_n_r;
	assign regulator_inhibit_output_out = 1'b1; // High level when enabled
	assign regulator_inhibit_oe_n_out   = inh_oe_n_r;
	assign pullup_en_out                = pullup_r;
	assign canh_drive_en_out            = canh_en_r;
	assign canl_drive_en_out            = canl_en_r;
	assign bus_dominant_out             = bus_dom_r;
	assign high_line_termination_en_out = hterm_r;
	assign low_line_termination_en_out  = lterm_r;
	assign low_line_termination_bat_out = lbat_r;
endmodule : ftcan_mode_ctrl
`default_nettype wire

// ### tb/ftcan_host_model.sv
// Host controller model that drives the two mode select pins
`timescale 1ns/1ns
`default_nettype none
module ftcan_host_model #(
	parameter int unsigned HOLD = 8
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Requests from the bench
	input  wire logic [1:0] pins_req_in,
	input  wire logic       sleep_req_in,
	input  wire logic       wake_ans_in,
	// Flags seen from the transceiver
	input  wire logic       rx_seen_in,
	input  wire logic       err_n_in,
	// Mode select pins
	output logic            standby_not_out,
	output logic            transfer_enable_out
);
	logic [15:0] hold_r; // Cycles spent in go-to-sleep

	// Wake answer first, then the sleep sequence, else plain pins
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			hold_r <= 16'h0;
			{standby_not_out, transfer_enable_out} <= 2'h0;
		end else if (wake_ans_in && !rx_seen_in && !err_n_in) begin
			{standby_not_out, transfer_enable_out} <= 2'h3;
		end else if (sleep_req_in) begin
			// Held a margin past the minimum before choosing sleep
			if (hold_r < 16'(HOLD + 2)) begin
				hold_r <= hold_r + 16'h1;
				{standby_not_out, transfer_enable_out} <= 2'h1;
			end else begin
				{standby_not_out, transfer_enable_out} <= 2'h0;
			end
		end else begin
			hold_r <= 16'h0;
			{standby_not_out, transfer_enable_out} <= pins_req_in;
		end
	end
endmodule : ftcan_host_model
`default_nettype wire

// ### tb/ftcan_mode_ctrl_checker.sv
// Concurrent checks on the mode controller ports
`timescale 1ns/1ns
`default_nettype none
module ftcan_mode_ctrl_checker #(
	parameter int unsigned FON_CYC  = 4,
	parameter int unsigned FOFF_CYC = 6
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Watched ports
	input wire logic standby_not_input_in,
	input wire logic transfer_enable_input_in,
	input wire logic transmit_line_in,
	input wire logic canl_fail_in,
	input wire logic battery_ok_in,
	input wire logic logic_ok_in,
	input wire logic overtemp_in,
	input wire logic regulator_inhibit_oe_n_out,
	input wire logic pullup_en_out,
	input wire logic canh_drive_en_out,
	input wire logic canl_drive_en_out,
	input wire logic bus_dominant_out,
	input wire logic low_line_termination_en_out,
	input wire logic low_line_termination_bat_out
);
	int fail_cnt_r; // Cycles the low-line failure has stood
	int ok_cnt_r;   // Cycles since it went away

	// Saturating run-length counters of the failure level
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			fail_cnt_r <= 0;
			ok_cnt_r   <= 0;
		end else begin
			fail_cnt_r <= canl_fail_in ? fail_cnt_r + int'(fail_cnt_r < 1000) : 0;
			ok_cnt_r   <= canl_fail_in ? 0 : ok_cnt_r + int'(ok_cnt_r < 1000);
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_ro_drv_off: assert property ((standby_not_input_in && !transfer_enable_input_in) [*3]
		|-> !canh_drive_en_out && !canl_drive_en_out) else $error("drivers on in receive-only");
	a_ovt_drv_off: assert property (overtemp_in [*3]
		|-> !canh_drive_en_out && !canl_drive_en_out) else $error("drivers on when hot");
	a_lowpwr_no_tx: assert property (!standby_not_input_in [*3]
		|-> !canh_drive_en_out && !canl_drive_en_out) else $error("drivers on in low power");
	a_tx_follow: assert property ((standby_not_input_in && transfer_enable_input_in && logic_ok_in
		&& battery_ok_in && !overtemp_in) [*3] |-> bus_dominant_out == !$past(transmit_line_in))
		else $error("bus level does not follow transmit input");
	a_inh_driven: assert property ((standby_not_input_in && logic_ok_in && battery_ok_in) [*3]
		|-> !regulator_inhibit_oe_n_out) else $error("inhibit not driven");
	a_sleep_pullup: assert property ((!standby_not_input_in && !transfer_enable_input_in
		&& logic_ok_in) [*3] |-> !pullup_en_out && low_line_termination_bat_out)
		else $error("pull-ups or low termination wrong in low power");
	a_canl_cut: assert property (fail_cnt_r > int'(FON_CYC) + 2
		|-> !low_line_termination_en_out && !canl_drive_en_out) else $error("low line not cut");
	a_canl_back: assert property (ok_cnt_r > int'(FOFF_CYC) + 2
		|-> low_line_termination_en_out) else $error("low line not restored");

	c_rx_only: cover property (standby_not_input_in && !transfer_enable_input_in);
	c_line_cut: cover property (!low_line_termination_en_out);
	c_inh_float: cover property (regulator_inhibit_oe_n_out);
endmodule : ftcan_mode_ctrl_checker
bind ftcan_mode_ctrl ftcan_mode_ctrl_checker #(.FON_CYC(FON_CYC), .FOFF_CYC(FOFF_CYC)) chk (.*);
`default_nettype wire

// ### tb/tb_ftcan_mode_ctrl.sv
// Self-checking bench of the fault tolerant CAN mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_ftcan_mode_ctrl;
	import ftcan_pkg::*;
	localparam int unsigned GT = 8, WK = 4, FON = 4, FOFF = 6, IDL = 10; // Short counts
	logic        clk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
	logic [1:0]  htrans_in = 2'h0, pins_req = 2'h0;
	logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, q;
	logic        transmit_line_in = 1'b1, local_edge_trigger_input_in = 1'b0;
	logic        diff_dominant_in = 1'b0, canh_dominant_in = 1'b0, canl_fail_in = 1'b0;
	logic        overtemp_in = 1'b0, battery_ok_in = 1'b1, logic_ok_in = 1'b1;
	logic        sleep_req = 1'b0, wake_ans = 1'b0, short_fail_in = 1'b0;
	wire logic   standby_not_input_in, transfer_enable_input_in, hreadyout_out;
	wire logic   [31:0] hrdata_out;
	wire logic   receive_line_out, error_flag_n_out, regulator_inhibit_oe_n_out, pullup_en_out;
	wire logic   canh_drive_en_out, canl_drive_en_out, bus_dominant_out;
	wire logic   low_line_termination_en_out, low_line_termination_bat_out;
	int          errors = 0, checks = 0;

	ftcan_mode_ctrl #(.GTS_CYC(GT), .WAKE_CYC(WK), .FON_CYC(FON), .FOFF_CYC(FOFF),
		.IDLE_CY(IDL)) uut (.*, .hsize_in(3'h2), .hready_in(hreadyout_out), .hresp_out(),
		.regulator_inhibit_output_out(), .canl_dominant_in(1'b0), .canh_fail_in(1'b0),
		.high_line_termination_en_out());
	ftcan_host_model #(.HOLD(GT)) host (.clk_in, .rst_in, .pins_req_in(pins_req),
		.sleep_req_in(sleep_req), .wake_ans_in(wake_ans), .rx_seen_in(receive_line_out),
		.err_n_in(error_flag_n_out), .standby_not_out(standby_not_input_in),
		.transfer_enable_out(transfer_enable_input_in));

	// Free running 250 MHz clock
	always #2 clk_in = ~clk_in;

	// Counts, verdict and end of run
	task conclude;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	// Word compare; values are read before the edge's updates land
	task cmp(input logic [31:0] g, e, input string m);
		checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : cmp
	task cb(input logic g, e, input string m);
		cmp({31'h0, g}, {31'h0, e}, m);
	endtask : cb
	task w(input int n);
		repeat (n) @(posedge clk_in);
	endtask : w
	// Waits for hready under a bound; a hang ends the run
	task hw;
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (hreadyout_out !== 1'b1 && n < 40);
		if (hreadyout_out !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: bus hang", $time);
			conclude();
		end
	endtask : hw
	// One single AHB-Lite transfer, address phase then data phase
	task xf(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel_in <= 1'b1;
		htrans_in <= 2'h2;
		hwrite_in <= wr;
		haddr_in <= {24'h0, a};
		hw();
		htrans_in <= 2'h0;
		hsel_in <= 1'b0;
		hwdata_in <= d;
		hw();
		q = hrdata_out;
	endtask : xf
	task md(input logic [2:0] e, input string m);
		xf(1'b0, ADDR_STATUS, 32'h0);
		cmp({29'h0, q[2:0]}, {29'h0, e}, m);
	endtask : md

	// Reset values, control write and read-back, unmapped place
	task t_regs;
		md(ST_STANDBY, "power-on mode");
		cb(q[ST_PON_BIT], 1'b1, "power-on flag");
		xf(1'b0, ADDR_CTRL, 32'h0);
		cmp(q, {30'h0, CTRL_RST}, "control reset");
		xf(1'b1, ADDR_CTRL, 32'h0);
		xf(1'b0, ADDR_CTRL, 32'h0);
		cmp(q, 32'h0, "control write");
		xf(1'b1, ADDR_CTRL, 32'h3);
		xf(1'b1, 8'h10, 32'hffff_ffff);
		xf(1'b0, 8'h10, 32'h0);
		cmp(q, 32'h0, "unmapped read");
	endtask : t_regs
	// Receive-only, then normal with data and over-temperature
	task t_modes;
		pins_req <= 2'h2;
		transmit_line_in <= 1'b0;
		diff_dominant_in <= 1'b1;
		w(5);
		md(ST_RXONLY, "receive-only mode");
		cb(canh_drive_en_out | canl_drive_en_out, 1'b0, "drivers in receive-only");
		cb(receive_line_out, 1'b0, "receive-only data");
		cb(error_flag_n_out, 1'b0, "power-on flag shown");
		pins_req <= 2'h3;
		diff_dominant_in <= 1'b0;
		w(5);
		md(ST_NORMAL, "normal mode");
		cb(q[ST_PON_BIT], 1'b0, "flag cleared");
		cb(error_flag_n_out, 1'b1, "error flag released");
		cb(receive_line_out, 1'b1, "recessive data");
		cb(bus_dominant_out & canh_drive_en_out, 1'b1, "dominant sent");
		overtemp_in <= 1'b1;
		diff_dominant_in <= 1'b1;
		w(5);
		cb(canh_drive_en_out | canl_drive_en_out, 1'b0, "drivers when hot");
		cb(receive_line_out, 1'b0, "reception when hot");
		overtemp_in <= 1'b0;
		diff_dominant_in <= 1'b0;
		transmit_line_in <= 1'b1;
		w(4);
		cb(bus_dominant_out, 1'b0, "recessive sent");
	endtask : t_modes
	// Held dominant failure, then low-line cut and restore
	task t_line;
		short_fail_in <= 1'b1;
		diff_dominant_in <= 1'b1;
		w(2);
		short_fail_in <= 1'b0;
		diff_dominant_in <= 1'b0;
		w(14);
		cb(error_flag_n_out, 1'b0, "short held");
		diff_dominant_in <= 1'b1;
		w(4);
		cb(error_flag_n_out, 1'b1, "short cleared");
		canl_fail_in <= 1'b1;
		w(2);
		cb(low_line_termination_en_out, 1'b1, "cut too early");
		w(10);
		cb(low_line_termination_en_out | canl_drive_en_out, 1'b0, "line cut");
		cb(error_flag_n_out, 1'b0, "failure flag");
		canl_fail_in <= 1'b0;
		w(3);
		cb(low_line_termination_en_out, 1'b0, "restore too early");
		w(12);
		cb(low_line_termination_en_out, 1'b1, "line restored");
	endtask : t_line
	// Sleep entry, filtered local wake, host answer, falling edge wake
	task t_sleep;
		sleep_req <= 1'b1;
		w(GT + 6);
		md(ST_SLEEP, "sleep entry");
		cb(regulator_inhibit_oe_n_out, 1'b1, "inhibit floats");
		local_edge_trigger_input_in <= 1'b1;
		w(2);
		local_edge_trigger_input_in <= 1'b0;
		w(WK + 6);
		md(ST_SLEEP, "short pulse ignored");
		local_edge_trigger_input_in <= 1'b1;
		w(WK + 6);
		md(ST_STANDBY, "local wake");
		cb(regulator_inhibit_oe_n_out, 1'b0, "inhibit on");
		cb(receive_line_out | error_flag_n_out, 1'b0, "wake reported");
		sleep_req <= 1'b0;
		wake_ans <= 1'b1;
		pins_req <= 2'h3;
		w(5);
		md(ST_NORMAL, "host answer");
		wake_ans <= 1'b0;
		pins_req <= 2'h0;
		w(4);
		local_edge_trigger_input_in <= 1'b0;
		w(WK + 6);
		cb(receive_line_out | error_flag_n_out, 1'b0, "falling edge wake");
		sleep_req <= 1'b1;
		w(GT + 6);
		canh_dominant_in <= 1'b1;
		w(WK + 6);
		canh_dominant_in <= 1'b0;
		md(ST_STANDBY, "one-line bus wake");
	endtask : t_sleep
	// Supply losses in go-to-sleep, in normal mode and in power-down
	task t_supply;
		sleep_req <= 1'b0;
		pins_req <= 2'h1;
		w(4);
		logic_ok_in <= 1'b0;
		w(4);
		md(ST_SLEEP, "logic loss after go-sleep");
		logic_ok_in <= 1'b1;
		pins_req <= 2'h3;
		w(5);
		md(ST_NORMAL, "back to normal");
		logic_ok_in <= 1'b0;
		w(4);
		md(ST_POWERDOWN, "logic loss");
		battery_ok_in <= 1'b0;
		w(4);
		md(ST_STANDBY, "battery loss");
		cb(q[ST_PON_BIT], 1'b1, "battery flag");
	endtask : t_supply

	// Main sequence
	initial begin
		w(2);
		rst_in <= 1'b0;
		t_regs();
		t_modes();
		t_line();
		t_sleep();
		t_supply();
		conclude();
	end
endmodule : tb_ftcan_mode_ctrl
`default_nettype wire
